// File: design/msio_pkg.sv
// Package: register map, reset values and carrier types of the mixed-signal port
package msio_pkg;

  // ==========================================================================
  // Register indices on the byte register port
  localparam logic [2:0] OUT_VALUE_ADDR   = 3'h0;  // pin_output_value
  localparam logic [2:0] IN_STATUS_ADDR   = 3'h1;  // pin_input_status
  localparam logic [2:0] DIRECTION_ADDR   = 3'h2;  // pin_direction
  localparam logic [2:0] OPEN_DRAIN_ADDR  = 3'h3;  // pin_open_drain
  localparam logic [2:0] PULLUP_ADDR      = 3'h4;  // pin_pullup_connect
  localparam logic [2:0] ANALOG_MODE_ADDR = 3'h5;  // pair_analog_mode
  localparam logic [2:0] FUNC_ENABLE_ADDR = 3'h6;  // peripheral enables

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PORT_RESET_VAL   = 8'h00;  // All configuration clears
  localparam logic [3:0] ANALOG_RESET_VAL = 4'h0;   // No pair in analog mode
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;  // Answer to unmapped address

  // ==========================================================================
  // Bit positions in the peripheral-enable register
  localparam int PWM0_EN_BIT   = 0;  // pwm_channel0_out_enable
  localparam int PWM1_EN_BIT   = 1;  // pwm_channel1_out_enable
  localparam int XTAL_OUT_BIT  = 2;  // crystal_clock_out_flag
  localparam int CPU_OUT_BIT   = 3;  // cpu_clock_out_flag
  localparam int SYNC_EN_BIT   = 4;  // sync_serial_enable
  localparam int TX_EN_BIT     = 5;  // async_transmit_enable
  localparam int RX_EN_BIT     = 6;  // async_receive_enable

  // ==========================================================================
  // Fixed pin assignments of the peripheral functions
  localparam int PWM0_PIN = 0;
  localparam int PWM1_PIN = 1;
  localparam int CPU_PIN  = 2;
  localparam int XTAL_PIN = 3;
  localparam int SYNC0_PIN = 4;
  localparam int SYNC1_PIN = 5;
  localparam int TX_PIN   = 6;
  localparam int RX_PIN   = 7;

  // Signals coming from on-chip peripherals
  typedef struct packed {
    logic       pwm0;        // PWM channel 0 level
    logic       pwm1;        // PWM channel 1 level
    logic       xtalClk;     // Crystal clock level
    logic       cpuClk;      // Processor clock level
    logic       syncLine0;   // sync_line0_value
    logic       syncLine1;   // sync_line1_value
    logic       syncOut0;    // Line 0 is an output
    logic       syncOut1;    // Line 1 is an output
    logic       txData;      // Async transmit level
  } msio_periph_s;

  // Per-pin analog switch control
  typedef struct packed {
    logic [7:0] connect;     // Switch closed for pin
    logic [15:0] lineSel;    // Two bits per pin: line 0..3
  } msio_analog_s;

endpackage : msio_pkg

// File: design/msio_port.sv
// Eight-pin mixed-signal port: registers, pin ownership and pad control
// Overview of operation
// - Analog bit moves pin pair to analog
// - Pull-up bit closes analog switch, else float
// - Odd pin line from output bits x,x-1
// - Even pin line from direction bits x+1,x
// - PWM channels replace output bits 0,1
// - Crystal clock drives pin 3 when flagged; code only replaces output bit 3, drive needs direction bit 3
// - Processor clock drives pin 2 when flagged; code only replaces output bit 2, drive needs direction bit 2
// - Sync serial makes pins 5,4 open-drain
// - Sync line outputs take their register bits; code takes level and direction from periph.syncLine0/1 and periph.syncOut0/1
// - Async serial owns pins 6 and 7
// - Direction one enables output, zero floats
// - Direction bits clear on reset
// - Input status reads pins directly, read-only
// - Input buffer active while pin outputs
// - Output bit drives only when direction set
// - Open-drain drives low or floats
// - Pull-up request bits, reset zero
// - Pull-up only for input or released open-drain
// - Input buffer off only in analog mode
// - Priority analog, then function, then digital
// - Four pair bits, upper bits read zero
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module msio_port
  import msio_pkg::*;
#(
  parameter int PINS = 8  // Port width
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Register port
  input  wire logic [2:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output var  logic [7:0]       regRdata,
  // Peripheral signals
  input  wire msio_periph_s     periph,
  output var  logic             rxData,
  output var  logic [1:0]       syncLineIn,
  // Pads
  input  wire logic [PINS-1:0]  padIn,
  output var  logic [PINS-1:0]  padOut,
  output var  logic [PINS-1:0]  padOe,
  output var  logic [PINS-1:0]  pullupOn,
  output var  logic [PINS-1:0]  inBufEn,
  // Analog switch control
  output var  msio_analog_s     analogCtl
);

  // ==========================================================================
  // Configuration registers
  logic [7:0] outValue_reg;   // pin_output_value
  logic [7:0] direction_reg;  // pin_direction
  logic [7:0] openDrain_reg;  // pin_open_drain
  logic [7:0] pullup_reg;     // pin_pullup_connect
  logic [3:0] anaMode_reg;    // pair_analog_mode
  logic [6:0] funcEn_reg;     // Peripheral enables

  // Combinational pad intent
  logic [7:0] padOut_next;    // Output level
  logic [7:0] padOe_next;     // Output enable
  logic [7:0] pullup_next;    // Effective pull-up
  logic [7:0] inBuf_next;     // Input buffer enable
  logic [7:0] anaPin;         // Pin in analog mode
  msio_analog_s analog_next;  // Switch settings

  // Expand pair bits to pins
  function automatic logic [7:0] pair_expand(input logic [3:0] pairs);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 4; i++) begin
      res[2*i]   = pairs[i];
      res[2*i+1] = pairs[i];
    end
    return res;
  endfunction : pair_expand

  // ==========================================================================
  // Register writes, visible the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      direction_reg <= PORT_RESET_VAL;
      outValue_reg  <= PORT_RESET_VAL;
      openDrain_reg <= PORT_RESET_VAL;
      pullup_reg    <= PORT_RESET_VAL;
      anaMode_reg   <= ANALOG_RESET_VAL;
      funcEn_reg    <= 7'h00;
    end else if (regWr) begin
      // Decode the write address
      case (regAddr)
        OUT_VALUE_ADDR:   outValue_reg  <= regWdata;
        DIRECTION_ADDR:   direction_reg <= regWdata;
        OPEN_DRAIN_ADDR:  openDrain_reg <= regWdata;
        PULLUP_ADDR:      pullup_reg    <= regWdata;
        ANALOG_MODE_ADDR: anaMode_reg   <= regWdata[3:0];
        FUNC_ENABLE_ADDR: funcEn_reg    <= regWdata[6:0];
        default: ;  // Input status and unmapped ignore writes
      endcase
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        OUT_VALUE_ADDR:   regRdata <= outValue_reg;
        IN_STATUS_ADDR:   regRdata <= padIn;
        DIRECTION_ADDR:   regRdata <= direction_reg;
        OPEN_DRAIN_ADDR:  regRdata <= openDrain_reg;
        PULLUP_ADDR:      regRdata <= pullup_reg;
        ANALOG_MODE_ADDR: regRdata <= {4'h0, anaMode_reg};
        FUNC_ENABLE_ADDR: regRdata <= {1'b0, funcEn_reg};
        default:          regRdata <= UNMAPPED_READ;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Pin ownership: analog over function over digital
  always_comb begin
    logic [7:0] od;   // Effective open-drain
    logic [7:0] dir;  // Effective direction
    logic [7:0] val;  // Effective output value
    od  = openDrain_reg;
    dir = direction_reg;
    val = outValue_reg;
    // PWM replaces value only; direction stays software's
    if (funcEn_reg[PWM0_EN_BIT]) val[PWM0_PIN] = periph.pwm0;
    if (funcEn_reg[PWM1_EN_BIT]) val[PWM1_PIN] = periph.pwm1;
    // Clock outputs replace value bits
    if (funcEn_reg[XTAL_OUT_BIT]) val[XTAL_PIN] = periph.xtalClk;
    if (funcEn_reg[CPU_OUT_BIT])  val[CPU_PIN]  = periph.cpuClk;
    // Sync serial forces open-drain lines
    if (funcEn_reg[SYNC_EN_BIT]) begin
      od[SYNC0_PIN]  = 1'b1;
      od[SYNC1_PIN]  = 1'b1;
      dir[SYNC0_PIN] = periph.syncOut0;
      dir[SYNC1_PIN] = periph.syncOut1;
      val[SYNC0_PIN] = periph.syncLine0;
      val[SYNC1_PIN] = periph.syncLine1;
    end
    // Async transmit and receive
    if (funcEn_reg[TX_EN_BIT]) begin
      dir[TX_PIN] = 1'b1;
      val[TX_PIN] = periph.txData;
      od[TX_PIN]  = 1'b0;
    end
    if (funcEn_reg[RX_EN_BIT]) begin
      dir[RX_PIN] = 1'b0;
      val[RX_PIN] = 1'b0;
    end
    // Analog pairs take the pins away from all else
    anaPin = pair_expand(anaMode_reg);
    for (int i = 0; i < 8; i++) begin
      // Drive only with direction set; open-drain drives low only
      padOe_next[i]  = !anaPin[i] && dir[i] && !(od[i] && val[i]);
      padOut_next[i] = padOe_next[i] && val[i];
      // Pull-up for input or released open-drain
      pullup_next[i] = !anaPin[i] && pullup_reg[i] && (!dir[i] || (od[i] && val[i]));
      // Input buffer on except in analog mode
      inBuf_next[i]  = !anaPin[i];
      // Analog switch and line select
      analog_next.connect[i] = anaPin[i] && pullup_reg[i];
      if (i % 2 == 1) begin
        analog_next.lineSel[2*i +: 2] = outValue_reg[i -: 2];
      end else begin
        analog_next.lineSel[2*i +: 2] = direction_reg[i +: 2];
      end
    end
  end

  // ==========================================================================
  // Registered pad and peripheral outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      padOut     <= '0;
      padOe      <= '0;
      pullupOn   <= '0;
      inBufEn    <= '1;
      analogCtl  <= '0;
      rxData     <= 1'b1;
      syncLineIn <= 2'b11;
    end else begin
      padOut     <= padOut_next;
      padOe      <= padOe_next;
      pullupOn   <= pullup_next;
      inBufEn    <= inBuf_next;
      analogCtl  <= analog_next;
      // Receive line idles high when not owned
      rxData     <= (funcEn_reg[RX_EN_BIT] && !anaPin[RX_PIN]) ? padIn[RX_PIN] : 1'b1;
      syncLineIn <= {padIn[SYNC1_PIN], padIn[SYNC0_PIN]};
    end
  end

  // ==========================================================================
  // Checks
  sequence anaWrite_seq;
    regWr && regAddr == ANALOG_MODE_ADDR && regWdata[0];
  endsequence

  analog_pair_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    anaWrite_seq |=> ##1 (!padOe[0] && !padOe[1] && !inBufEn[0]))
    else $error("analog pair still drives");
  analog_connect_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (anaMode_reg[1] && !pullup_reg[3]) |=> !analogCtl.connect[3])
    else $error("analog switch closed without connect bit");
  odd_line_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> analogCtl.lineSel[7:6] == $past(outValue_reg[3:2]))
    else $error("odd pin line select wrong");
  even_line_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> analogCtl.lineSel[5:4] == $past(direction_reg[3:2]))
    else $error("even pin line select wrong");
  pwm_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[PWM0_EN_BIT] && direction_reg[0] && !openDrain_reg[0] && !anaMode_reg[0])
      |=> padOut[0] == $past(periph.pwm0))
    else $error("pwm not on pin 0");
  dir_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (direction_reg == 8'h00 && funcEn_reg == 7'h00) |=> padOe == 8'h00)
    else $error("output enabled with direction zero");
  reset_dir_a: assert property (@(posedge ref_clk)
    !nrst |=> (direction_reg == 8'h00 && padOe == 8'h00))
    else $error("direction not cleared by reset");
  status_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (regRd && regAddr == IN_STATUS_ADDR) |=> regRdata == $past(padIn))
    else $error("input status not direct");
  open_drain_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (openDrain_reg[7] && outValue_reg[7] && !anaMode_reg[3] && funcEn_reg == 7'h00) |=> !padOe[7])
    else $error("open-drain drives high");
  pullup_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (padOe_next[6] && padOut_next[6]) |=> !pullupOn[6])
    else $error("pull-up on while driving");
  ana_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (regRd && regAddr == ANALOG_MODE_ADDR) |=> regRdata[7:4] == 4'h0)
    else $error("analog upper bits not zero");

  // ==========================================================================
  // Function and digital checks
  // Every check below but reset_cfg_a and write_next_a compares a registered output against the
  // configuration that stood one edge earlier, so a write landing in
  // the same cycle cannot make them fire.
  sequence dirWrite_seq;
    regWr && regAddr == DIRECTION_ADDR;
  endsequence

  sequence xtalOwn_seq;
    funcEn_reg[XTAL_OUT_BIT] && direction_reg[XTAL_PIN] && !openDrain_reg[XTAL_PIN] && !anaMode_reg[1];
  endsequence

  // Analog switch closes when the connect bit is set
  analog_close_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (anaMode_reg[0] && pullup_reg[1])
      |=> analogCtl.connect[1])
    else $error("analog switch open with connect bit");

  // Second PWM channel on pin 1
  pwm1_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[PWM1_EN_BIT] && direction_reg[1] && !openDrain_reg[1] && !anaMode_reg[0])
      |=> padOut[1] == $past(periph.pwm1))
    else $error("pwm not on pin 1");

  // Crystal clock on pin 3
  xtal_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    xtalOwn_seq
      |=> (padOe[3] && padOut[3] == $past(periph.xtalClk)))
    else $error("crystal clock not on pin 3");

  // Processor clock on pin 2
  cpu_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[CPU_OUT_BIT] && direction_reg[CPU_PIN] && !openDrain_reg[CPU_PIN] && !anaMode_reg[1])
      |=> (padOe[2] && padOut[2] == $past(periph.cpuClk)))
    else $error("processor clock not on pin 2");

  // Sync line released high floats
  sync_float_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[SYNC_EN_BIT] && !anaMode_reg[2] && periph.syncLine1)
      |=> !padOe[5])
    else $error("sync line driven high");

  // Sync line 0 output low pulls pin 4
  sync_low0_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[SYNC_EN_BIT] && !anaMode_reg[2] && periph.syncOut0 && !periph.syncLine0)
      |=> (padOe[4] && !padOut[4]))
    else $error("sync line 0 not low");

  // Sync line 1 output low pulls pin 5
  sync_low1_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[SYNC_EN_BIT] && !anaMode_reg[2] && periph.syncOut1 && !periph.syncLine1)
      |=> (padOe[5] && !padOut[5]))
    else $error("sync line 1 not low");

  // Transmit drives pin 6
  tx_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[TX_EN_BIT] && !anaMode_reg[3])
      |=> (padOe[6] && padOut[6] == $past(periph.txData)))
    else $error("transmit not on pin 6");

  // Receive takes pin 7 as input
  rx_pin_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (funcEn_reg[RX_EN_BIT] && !anaMode_reg[3])
      |=> (!padOe[7] && rxData == $past(padIn[RX_PIN])))
    else $error("receive not from pin 7");

  // Input buffer stays on for an output
  out_readback_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (direction_reg[0] && !anaMode_reg[0])
      |=> inBufEn[0])
    else $error("input buffer off while output");

  // Push-pull pin drives its output bit
  out_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (direction_reg[7] && !openDrain_reg[7] && !anaMode_reg[3] && funcEn_reg == 7'h00)
      |=> (padOe[7] && padOut[7] == $past(outValue_reg[7])))
    else $error("output bit not driven");

  // Input pin never drives
  out_float_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !direction_reg[0]
      |=> !padOe[0])
    else $error("input pin driven");

  // Requested pull-up on a digital input
  pullup_req_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pullup_reg[0] && !direction_reg[0] && !anaMode_reg[0])
      |=> pullupOn[0])
    else $error("pull-up request ignored");

  // No pull-up without request
  pullup_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pullup_reg[0]
      |=> !pullupOn[0])
    else $error("pull-up on without request");

  // Configuration bits clear on reset
  reset_cfg_a: assert property (@(posedge ref_clk)
    !nrst
      |=> (outValue_reg == 8'h00 && openDrain_reg == 8'h00 && pullup_reg == 8'h00))
    else $error("configuration not cleared by reset");

  // Analog pair turns input buffers off
  inbuf_ana_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    anaMode_reg[2]
      |=> (!inBufEn[4] && !inBufEn[5]))
    else $error("input buffer on in analog mode");

  // Analog wins over the async functions
  ana_priority_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    anaMode_reg[3]
      |=> (!padOe[6] && !padOe[7] && !pullupOn[6] && !pullupOn[7]))
    else $error("analog pair still digital");

  // Written value held from the next cycle
  write_next_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    dirWrite_seq
      |=> direction_reg == $past(regWdata))
    else $error("direction write not taken");

endmodule : msio_port

`default_nettype wire

// File: testbench/msio_pad_model.sv
// Pad partner: resolves each pin from device drive, outside driver and pull-up
`timescale 1ns/100ps
`default_nettype none
module msio_pad_model (
  // Clock
  input  wire logic       ref_clk,
  // Device side
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] pullupOn,
  // Outside driver
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  // Resolved pin level
  output var  logic [7:0] padIn
);
  logic [7:0] floatPat = 8'h55;  // Undriven pins wander
  // Flip every rising edge so a stale level never passes for a real one
  always_ff @(posedge ref_clk) floatPat <= ~floatPat;
  // Device first, then outside driver, then pull-up
  always_comb padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & (pullupOn | floatPat));
endmodule : msio_pad_model
`default_nettype wire

// File: testbench/test_msio_port.sv
// Self-checking bench for the mixed-signal port
`timescale 1ns/100ps
`default_nettype none
module test_msio_port
  import msio_pkg::*;
;
  // ==========================================
  // Signals
  logic         ref_clk, nrst, regWr, regRd, rxData;
  logic [2:0]   regAddr;
  logic [7:0]   regWdata, regRdata, padIn, padOut, padOe, pullupOn, inBufEn, extEn, extVal;
  logic [1:0]   syncLineIn;
  logic [15:0]  expSel;
  logic [7:0]   selOut = 8'h1b;  // Line codes for odd pins
  logic [7:0]   selDir = 8'he4;  // Line codes for even pins
  msio_periph_s periph;
  msio_analog_s analogCtl;
  int           errTotal, comparisons;
  // ==========================================
  // Clock, device and pads
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  msio_port #(.PINS(8)) dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .periph(periph), .rxData(rxData),
    .syncLineIn(syncLineIn), .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn),
    .inBufEn(inBufEn), .analogCtl(analogCtl));
  msio_pad_model pads (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn),
    .extEn(extEn), .extVal(extVal), .padIn(padIn));
  // ==========================================
  // Tasks
  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask : wr
  // One-cycle read, data checked in the next cycle
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, regRdata});
  endtask : rd
  // Register then pad flop
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // Counts and verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    report_and_stop();
  end
  // ==========================================
  // Tests
  initial begin
    nrst     = 1'b0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regAddr  = 3'h0;
    regWdata = 8'h00;
    periph   = '0;
    extEn    = 8'h00;
    extVal   = 8'h00;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    // Reset state of pads and registers
    #1 chk("padOe", 16'h0000, {8'h00, padOe});
    chk("inBufEn", 16'h00ff, {8'h00, inBufEn});
    chk("pullupOn", 16'h0000, {8'h00, pullupOn});
    foreach (selOut[i]) if (i < 6 && i != 1) rd(i[2:0], PORT_RESET_VAL, "reset reg");
    rd(3'h7, UNMAPPED_READ, "unmapped");
    $display("reset test done");
    // Push-pull, open-drain and pull-up gating
    wr(DIRECTION_ADDR, 8'hff);
    wr(OUT_VALUE_ADDR, 8'ha5);
    settle();
    chk("padOe", 16'h00ff, {8'h00, padOe});
    chk("padOut", 16'h00a5, {8'h00, padOut});
    rd(IN_STATUS_ADDR, 8'ha5, "readback");
    wr(OPEN_DRAIN_ADDR, 8'h0f);
    wr(PULLUP_ADDR, 8'hff);
    settle();
    chk("od padOe", 16'h00fa, {8'h00, padOe});
    chk("od drive", 16'h00a0, {8'h00, padOut & padOe});
    chk("pullupOn", 16'h0005, {8'h00, pullupOn});
    rd(IN_STATUS_ADDR, 8'ha5, "od readback");
    wr(DIRECTION_ADDR, 8'h00);
    settle();
    chk("in padOe", 16'h0000, {8'h00, padOe});
    chk("in pullupOn", 16'h00ff, {8'h00, pullupOn});
    $display("digital test done");
    // Direct input status, writes refused
    wr(PULLUP_ADDR, 8'h00);
    wr(IN_STATUS_ADDR, 8'hff);
    foreach (selDir[i]) if (i < 2) begin
      @(posedge ref_clk);
      extEn  <= 8'hff;
      extVal <= i ? 8'hc3 : 8'h3c;
      rd(IN_STATUS_ADDR, i ? 8'hc3 : 8'h3c, "status");
    end
    $display("input test done");
    // Analog mode, line select and connect
    @(posedge ref_clk);
    extEn <= 8'h00;
    wr(OUT_VALUE_ADDR, selOut);
    wr(DIRECTION_ADDR, selDir);
    wr(PULLUP_ADDR, 8'h5a);
    wr(ANALOG_MODE_ADDR, 8'hff);
    settle();
    rd(ANALOG_MODE_ADDR, 8'h0f, "analog reg");
    for (int i = 0; i < 8; i++) expSel[2*i +: 2] = i[0] ? selOut[i -: 2] : selDir[i+1 -: 2];
    chk("lineSel", expSel, analogCtl.lineSel);
    chk("connect", 16'h005a, {8'h00, analogCtl.connect});
    chk("an padOe", 16'h0000, {8'h00, padOe | pullupOn | inBufEn});
    wr(PULLUP_ADDR, 8'h00);
    settle();
    chk("open sw", 16'h0000, {8'h00, analogCtl.connect});
    wr(ANALOG_MODE_ADDR, 8'h02);
    wr(PULLUP_ADDR, 8'hff);
    settle();
    chk("pair connect", 16'h000c, {8'h00, analogCtl.connect});
    chk("pair inBufEn", 16'h00f3, {8'h00, inBufEn});
    chk("pair padOe", 16'h00e0, {8'h00, padOe});
    $display("analog test done");
    // Peripheral functions
    wr(ANALOG_MODE_ADDR, 8'h00);
    wr(PULLUP_ADDR, 8'h00);
    wr(OUT_VALUE_ADDR, 8'h00);
    wr(OPEN_DRAIN_ADDR, 8'h00);
    wr(DIRECTION_ADDR, 8'hff);
    wr(FUNC_ENABLE_ADDR, 8'h2f);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      periph.pwm0    <= v[0];
      periph.pwm1    <= v[0];
      periph.xtalClk <= v[0];
      periph.cpuClk  <= v[0];
      periph.txData  <= v[0];
      settle();
      chk("fn padOut", v ? 16'h004f : 16'h0000, {8'h00, padOut & 8'h4f});
      chk("fn padOe", 16'h004f, {8'h00, padOe & 8'h4f});
    end
    @(posedge ref_clk);
    extEn  <= 8'h80;
    extVal <= 8'h00;
    wr(FUNC_ENABLE_ADDR, 8'h40);
    settle();
    chk("rx", 16'h0000, {15'h0000, rxData | padOe[7]});
    wr(ANALOG_MODE_ADDR, 8'h08);
    settle();
    chk("rx analog", 16'h0001, {15'h0000, rxData});
    wr(ANALOG_MODE_ADDR, 8'h00);
    wr(PULLUP_ADDR, 8'h30);
    @(posedge ref_clk);
    periph.syncOut0 <= 1'b1;
    extEn           <= 8'h20;
    wr(FUNC_ENABLE_ADDR, 8'h10);
    settle();
    chk("sync oe", 16'h0001, {14'h0000, padOe[5:4]});
    chk("sync low", 16'h0000, {15'h0000, padOut[4]});
    chk("sync pu", 16'h0002, {14'h0000, pullupOn[5:4]});
    chk("sync in1", 16'h0000, {15'h0000, syncLineIn[1]});
    @(posedge ref_clk);
    periph.syncLine0 <= 1'b1;
    settle();
    chk("sync free", 16'h0000, {14'h0000, padOe[5:4]});
    chk("sync pu2", 16'h0003, {14'h0000, pullupOn[5:4]});
    chk("sync in0", 16'h0001, {15'h0000, syncLineIn[0]});
    $display("function test done");
    report_and_stop();
  end
endmodule : test_msio_port
`default_nettype wire
